/* File: hdl/lcd_serial_parallel_port.sv */
// Contract
// - serial words are shifted out at widths of 8, 9, 16, 18, 24 or 32 bits.
// - the serial link runs four-wire with a separate select pin or three-wire without it.
// - in three-wire mode one extra bit carrying the command/data select leads each word.
// - while idle the serial clock is low and the active-low chip enable is high.
// - once enabled and loaded, chip enable goes low and stays low for the whole word.
// - parallel panels get an 8080 bus with 9-bit data, read and write strobes, address and chip select.
// - display data may come from the internal SRAM port or the external memory port.
// - pixels are packed as 3-3-2, 4-4-4, 5-6-5, 6-6-6 or 8-8-8.
`timescale 1ns/100ps
module lcd_serial_parallel_port (
	// clocks and reset
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_clk_link,
	input  wire logic                         i_rstn,
	// configuration
	input  wire logic                         i_enable,
	input  wire logic                         i_three_wire,
	// request
	input  wire logic                         i_req_valid,
	input  wire lcd_port_pkg::req_t           i_req,
	input  wire logic [31:0]                  i_int_sram_data,
	input  wire logic [31:0]                  i_ext_mem_data,
	output logic                              o_req_ready,
	// read answer
	output logic                              o_rd_valid,
	output logic      [8:0]                   o_rd_data,
	// serial panel pins
	output logic                              o_serial_chip_enable_n,
	output logic                              o_serial_clock_out,
	output logic                              o_serial_data_out,
	output logic                              o_command_data_select,
	// parallel panel pins
	output logic                              o_parallel_read_strobe_n,
	output logic                              o_parallel_write_strobe_n,
	output logic                              o_parallel_address_line,
	output logic                              o_parallel_chip_select_n,
	output logic      [8:0]                   o_par_data,
	output logic                              o_par_data_oe,
	input  wire logic [8:0]                   i_par_data,
	output logic                              o_panel_reset_n
);
	typedef enum logic [2:0] {S_IDLE, S_SER_WAIT, S_PAR_SETUP, S_PAR_STROBE, S_PAR_HOLD} sys_state_t;
	typedef enum logic {L_IDLE, L_SHIFT} link_state_t;

	// reset release, one copy per domain
	logic rst_s1_q, rst_s2_q, lrst_s1_q, lrst_s2_q;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	always_ff @(posedge i_clk_link or negedge i_rstn) begin
		if (!i_rstn) begin
			lrst_s1_q <= 1'b0;
			lrst_s2_q <= 1'b0;
		end else begin
			lrst_s1_q <= 1'b1;
			lrst_s2_q <= lrst_s1_q;
		end
	end
	assign o_panel_reset_n = rst_s2_q;

	// ---------------- system domain ----------------
	sys_state_t                           state_q, state_d;
	logic [3:0]                           cnt_q;
	logic                                 is_read_q, cd_q, three_q, req_tgl_q;
	logic [lcd_port_pkg::DATA_W-1:0]      data_q;
	logic [lcd_port_pkg::FRAME_W-1:0]     frame_q;
	logic [lcd_port_pkg::CNT_W-1:0]       nbits_q;
	logic                                 done_s1_q, done_s2_q, done_tgl_q;
	logic [8:0]                           pin_s1_q, pin_s2_q;
	logic                                 rd_valid_q;
	logic [8:0]                           rd_data_q;

	wire logic                            take;
	wire logic [31:0]                     src_word;
	wire logic [31:0]                     pix_word;
	wire logic [lcd_port_pkg::CNT_W-1:0]  n_bits;
	wire logic [31:0]                     aligned;
	wire logic                            ser_done;
	wire logic                            strobe_end;

	assign o_req_ready = (state_q == S_IDLE) && i_enable;
	assign take        = i_req_valid && o_req_ready;
	assign src_word    = i_req.from_ext ? i_ext_mem_data : i_int_sram_data;
	assign n_bits      = lcd_port_pkg::width_bits(i_req.width);
	assign aligned     = pix_word << (6'(lcd_port_pkg::DATA_W) - n_bits);
	assign ser_done    = (done_s2_q == req_tgl_q);
	assign strobe_end  = (cnt_q == lcd_port_pkg::STROBE_LAST);

	pixel_pack u_pack (
		.i_word   (src_word),
		.i_fmt    (i_req.pix),
		.o_packed (pix_word)
	);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE:       if (take) state_d = i_req.to_parallel ? S_PAR_SETUP : S_SER_WAIT;
			S_SER_WAIT:   if (ser_done) state_d = S_IDLE;
			S_PAR_SETUP:  state_d = S_PAR_STROBE;
			S_PAR_STROBE: if (strobe_end) state_d = S_PAR_HOLD;
			S_PAR_HOLD:   state_d = S_IDLE;
			default:      state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			state_q   <= S_IDLE;
			cnt_q     <= '0;
			is_read_q <= 1'b0;
			cd_q      <= 1'b0;
			three_q   <= 1'b0;
			req_tgl_q <= 1'b0;
			data_q    <= '0;
			frame_q   <= '0;
			nbits_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= (state_q == S_PAR_STROBE) ? cnt_q + 4'h1 : 4'h0;
			if (take) begin
				is_read_q <= i_req.is_read;
				cd_q      <= i_req.cd_sel;
				three_q   <= i_three_wire;
				data_q    <= pix_word;
				frame_q   <= i_three_wire ? {i_req.cd_sel, aligned} : {aligned, 1'b0};
				nbits_q   <= n_bits + 6'(i_three_wire);
				if (!i_req.to_parallel)
					req_tgl_q <= ~req_tgl_q;
			end
		end
	end

	// completion toggle and read pins enter through two flops
	always_ff @(posedge i_clk_sys or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			done_s1_q  <= 1'b0;
			done_s2_q  <= 1'b0;
			pin_s1_q   <= '0;
			pin_s2_q   <= '0;
			rd_valid_q <= 1'b0;
			rd_data_q  <= '0;
		end else begin
			done_s1_q  <= done_tgl_q;
			done_s2_q  <= done_s1_q;
			pin_s1_q   <= i_par_data;
			pin_s2_q   <= pin_s1_q;
			rd_valid_q <= (state_q == S_PAR_HOLD) && is_read_q;
			if ((state_q == S_PAR_HOLD) && is_read_q)
				rd_data_q <= pin_s2_q;
		end
	end
	assign o_rd_valid = rd_valid_q;
	assign o_rd_data  = rd_data_q;

	// 8080 bus decode
	wire logic par_active;
	assign par_active                = (state_q == S_PAR_SETUP) || (state_q == S_PAR_STROBE) || (state_q == S_PAR_HOLD);
	assign o_parallel_chip_select_n  = !par_active;
	assign o_parallel_address_line   = par_active && cd_q;
	assign o_parallel_write_strobe_n = !((state_q == S_PAR_STROBE) && !is_read_q);
	assign o_parallel_read_strobe_n  = !((state_q == S_PAR_STROBE) && is_read_q);
	assign o_par_data_oe             = par_active && !is_read_q;
	assign o_par_data                = data_q[lcd_port_pkg::PAR_W-1:0];

	// ---------------- link domain ----------------
	link_state_t                          lstate_q;
	logic                                 req_s1_q, req_s2_q, req_seen_q;
	logic [lcd_port_pkg::FRAME_W-1:0]     sr_q;
	logic [lcd_port_pkg::CNT_W-1:0]       left_q, lcount_q, rises_q;
	logic                                 sck_q, sda_q, cs_n_q, a0_q, lthree_q, lcd_q;
	wire logic                            start;

	assign start = (lstate_q == L_IDLE) && (req_s2_q != req_seen_q);

	always_ff @(posedge i_clk_link or negedge lrst_s2_q) begin
		if (!lrst_s2_q) begin
			lstate_q   <= L_IDLE;
			req_s1_q   <= 1'b0;
			req_s2_q   <= 1'b0;
			req_seen_q <= 1'b0;
			done_tgl_q <= 1'b0;
			sr_q       <= '0;
			left_q     <= '0;
			lcount_q   <= '0;
			sck_q      <= 1'b0;
			sda_q      <= 1'b0;
			cs_n_q     <= 1'b1;
			a0_q       <= 1'b0;
			lthree_q   <= 1'b0;
			lcd_q      <= 1'b0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			unique case (lstate_q)
				L_IDLE: begin
					sck_q  <= 1'b0;
					cs_n_q <= 1'b1;
					if (start) begin
						req_seen_q <= req_s2_q;
						lstate_q   <= L_SHIFT;
						sr_q       <= frame_q;
						left_q     <= nbits_q;
						lcount_q   <= nbits_q;
						lthree_q   <= three_q;
						lcd_q      <= cd_q;
						sda_q      <= frame_q[lcd_port_pkg::FRAME_W-1];
						a0_q       <= three_q ? 1'b0 : cd_q;
						cs_n_q     <= 1'b0;
					end
				end
				L_SHIFT: begin
					if (!sck_q) begin
						sck_q <= 1'b1;
					end else begin
						sck_q <= 1'b0;
						if (left_q == 6'h01) begin
							lstate_q   <= L_IDLE;
							cs_n_q     <= 1'b1;
							sda_q      <= 1'b0;
							done_tgl_q <= ~done_tgl_q;
						end else begin
							sr_q   <= sr_q << 1;
							sda_q  <= sr_q[lcd_port_pkg::FRAME_W-2];
							left_q <= left_q - 6'h01;
						end
					end
				end
			endcase
		end
	end

	assign o_serial_chip_enable_n = cs_n_q;
	assign o_serial_clock_out     = sck_q;
	assign o_serial_data_out      = sda_q;
	assign o_command_data_select  = a0_q;

	// checking helpers
	always_ff @(posedge i_clk_link or negedge lrst_s2_q) begin
		if (!lrst_s2_q)
			rises_q <= '0;
		else if (start)
			rises_q <= '0;
		else if ((lstate_q == L_SHIFT) && !sck_q)
			rises_q <= rises_q + 6'h01;
	end

	sequence seq_strobe_pulse(sig);
		!sig ##1 !sig ##1 sig;
	endsequence

	chk_idle_lines: assert property (@(posedge i_clk_link) disable iff (!lrst_s2_q)
		(lstate_q == L_IDLE) && !$past(start) |-> !o_serial_clock_out && o_serial_chip_enable_n)
		else $error("serial lines not idle");
	chk_ce_frame: assert property (@(posedge i_clk_link) disable iff (!lrst_s2_q)
		$fell(o_serial_chip_enable_n) |=> !o_serial_chip_enable_n && o_serial_clock_out)
		else $error("chip enable rose before first clock");
	chk_sda_on_high: assert property (@(posedge i_clk_link) disable iff (!lrst_s2_q)
		o_serial_clock_out |-> $stable(o_serial_data_out))
		else $error("serial data moved while clock high");
	chk_lead_cd_bit: assert property (@(posedge i_clk_link) disable iff (!lrst_s2_q)
		$fell(o_serial_chip_enable_n) && lthree_q |-> o_serial_data_out == lcd_q)
		else $error("three-wire lead bit wrong");
	chk_bit_count: assert property (@(posedge i_clk_link) disable iff (!lrst_s2_q)
		$rose(o_serial_chip_enable_n) |-> rises_q == lcount_q)
		else $error("serial clock count wrong");
	chk_four_wire_cd: assert property (@(posedge i_clk_link) disable iff (!lrst_s2_q)
		!o_serial_chip_enable_n && !lthree_q |-> o_command_data_select == lcd_q)
		else $error("select pin wrong in four-wire");
	chk_wr_strobe: assert property (@(posedge i_clk_sys) disable iff (!rst_s2_q)
		$fell(o_parallel_write_strobe_n) |-> seq_strobe_pulse(o_parallel_write_strobe_n))
		else $error("write strobe width wrong");
	chk_strobe_in_cs: assert property (@(posedge i_clk_sys) disable iff (!rst_s2_q)
		!(o_parallel_write_strobe_n && o_parallel_read_strobe_n) |-> !o_parallel_chip_select_n ##1 !o_parallel_chip_select_n)
		else $error("strobe outside chip select");
	chk_ser_finishes: assert property (@(posedge i_clk_sys) disable iff (!rst_s2_q)
		take && !i_req.to_parallel |=> ##[1:300] (state_q == S_IDLE))
		else $error("serial word never completed");
endmodule

/* File: pkg/lcd_port_pkg.sv */
package lcd_port_pkg;

	// serial transaction widths
	typedef enum logic [2:0] {
		WID_8,
		WID_9,
		WID_16,
		WID_18,
		WID_24,
		WID_32
	} width_t;

	// pixel colour depths, raw passes data unchanged
	typedef enum logic [2:0] {
		PIX_RAW,
		PIX_332,
		PIX_444,
		PIX_565,
		PIX_666,
		PIX_888
	} pix_fmt_t;

	typedef struct packed {
		logic     to_parallel;
		logic     is_read;
		logic     cd_sel;
		logic     from_ext;
		width_t   width;
		pix_fmt_t pix;
	} req_t;

	localparam int DATA_W  = 32;
	localparam int PAR_W   = 9;
	localparam int FRAME_W = 33;
	localparam int CNT_W   = 6;
	localparam int RGB_W   = 24;

	// strobe timing on the system clock
	localparam int SYS_CLK_NS  = 40;
	localparam int T_STROBE_NS = 80;
	localparam int STROBE_CYC  = (T_STROBE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);

	function automatic logic [CNT_W-1:0] width_bits(input width_t w);
		logic [CNT_W-1:0] n;
		n = 6'h08;
		unique case (w)
			WID_8:   n = 6'h08;
			WID_9:   n = 6'h09;
			WID_16:  n = 6'h10;
			WID_18:  n = 6'h12;
			WID_24:  n = 6'h18;
			WID_32:  n = 6'h20;
			default: n = 6'h08;
		endcase
		return n;
	endfunction

endpackage

/* File: hdl/pixel_pack.sv */
`timescale 1ns/100ps
module pixel_pack (
	// source word and depth
	input  wire logic [31:0]               i_word,
	input  wire lcd_port_pkg::pix_fmt_t    i_fmt,
	// packed pixel, right aligned
	output logic      [31:0]               o_packed
);
	wire logic [7:0] red;
	wire logic [7:0] grn;
	wire logic [7:0] blu;

	assign red = i_word[23:16];
	assign grn = i_word[15:8];
	assign blu = i_word[7:0];

	always_comb begin
		o_packed = i_word;
		unique case (i_fmt)
			lcd_port_pkg::PIX_RAW: o_packed = i_word;
			lcd_port_pkg::PIX_332: o_packed = 32'({red[7:5], grn[7:5], blu[7:6]});
			lcd_port_pkg::PIX_444: o_packed = 32'({red[7:4], grn[7:4], blu[7:4]});
			lcd_port_pkg::PIX_565: o_packed = 32'({red[7:3], grn[7:2], blu[7:3]});
			lcd_port_pkg::PIX_666: o_packed = 32'({red[7:2], grn[7:2], blu[7:2]});
			lcd_port_pkg::PIX_888: o_packed = 32'({red, grn, blu});
			default:               o_packed = i_word;
		endcase
	end
endmodule

/* File: tb/panel_model.sv */
`timescale 1ns/100ps
module panel_model (
	// serial pins
	input  wire logic       i_cs_n,
	input  wire logic       i_sck,
	input  wire logic       i_sda,
	input  wire logic       i_a0,
	// parallel pins
	input  wire logic       i_pcs_n,
	input  wire logic       i_wr_n,
	input  wire logic       i_rd_n,
	input  wire logic       i_oe,
	input  wire logic       i_pa0,
	input  wire logic [8:0] i_pdata,
	input  wire logic [8:0] i_rd_word,
	output logic      [8:0] o_pdata
);
	logic [63:0] sr = '0;
	int          cnt = 0;
	int          viol = 0;
	logic        a0_s = 1'b0;
	logic [8:0]  wr_word = '0;
	logic        wr_a0 = 1'b0;
	realtime     t_sda = 0;
	realtime     t_rise = 0;
	always @(negedge i_cs_n) cnt = 0;
	// shift in on rising serial clock
	always @(posedge i_sck) begin
		if (i_cs_n) viol++;
		else begin
			if (t_sda == $realtime) viol++;
			sr = {sr[62:0], i_sda};
			if (cnt == 0) a0_s = i_a0;
			cnt++;
		end
		t_rise = $realtime;
	end
	always @(i_sda) t_sda = $realtime;
	// data may move at the falling edge, never inside the high phase
	always @(negedge i_sck) if (t_sda > t_rise && t_sda < $realtime) viol++;
	always @(negedge i_rd_n) if (i_oe || i_pcs_n) viol++;
	always @(posedge i_wr_n) if (!i_pcs_n) begin
		if (!i_oe) viol++;
		wr_word = i_pdata;
		wr_a0 = i_pa0;
	end
	// bus released: inverse of read word
	assign o_pdata = (!i_pcs_n && !i_rd_n) ? i_rd_word : ~i_rd_word;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
	logic               i_clk_sys = 0;
	logic               i_clk_link = 0;
	logic               i_rstn = 0;
	logic               i_enable = 0;
	logic               i_three_wire = 0;
	logic               i_req_valid = 0;
	lcd_port_pkg::req_t i_req = '0;
	logic [31:0]        i_int_sram_data = '0;
	logic [31:0]        i_ext_mem_data = '0;
	logic [8:0]         i_par_data;
	logic               o_req_ready, o_rd_valid, cs_n, sck, sda, a0;
	logic               rd_n, wr_n, pa0, pcs_n, oe, prst_n;
	logic [8:0]         o_rd_data, o_par_data;
	int                 err_total = 0;
	int                 checks = 0;
	int                 rdv_cnt = 0;
	always #20 i_clk_sys = ~i_clk_sys;
	always #62.5 i_clk_link = ~i_clk_link;
	always @(posedge i_clk_sys) if (o_rd_valid === 1'b1) rdv_cnt++;
	lcd_serial_parallel_port dut_u (.i_clk_sys(i_clk_sys), .i_clk_link(i_clk_link), .i_rstn(i_rstn),
		.i_enable(i_enable), .i_three_wire(i_three_wire), .i_req_valid(i_req_valid), .i_req(i_req),
		.i_int_sram_data(i_int_sram_data), .i_ext_mem_data(i_ext_mem_data), .o_req_ready(o_req_ready),
		.o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_serial_chip_enable_n(cs_n),
		.o_serial_clock_out(sck), .o_serial_data_out(sda), .o_command_data_select(a0),
		.o_parallel_read_strobe_n(rd_n), .o_parallel_write_strobe_n(wr_n), .o_parallel_address_line(pa0),
		.o_parallel_chip_select_n(pcs_n), .o_par_data(o_par_data), .o_par_data_oe(oe),
		.i_par_data(i_par_data), .o_panel_reset_n(prst_n));
	panel_model pm (.i_cs_n(cs_n), .i_sck(sck), .i_sda(sda), .i_a0(a0), .i_pcs_n(pcs_n), .i_wr_n(wr_n),
		.i_rd_n(rd_n), .i_oe(oe), .i_pa0(pa0), .i_pdata(o_par_data), .i_rd_word(9'h1a5), .o_pdata(i_par_data));
	task automatic chk(input logic [32:0] exp, input logic [32:0] act);
		checks++;
		if (act !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t exp=%h act=%h", $time, exp, act);
		end
	endtask
	task automatic report_and_stop();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge i_clk_sys);
		while (o_req_ready !== 1'b1) begin
			n++;
			if (n > 2000) begin
				chk(33'd1, 33'(o_req_ready));
				report_and_stop();
			end
			@(posedge i_clk_sys);
		end
		#1;
	endtask
	task automatic send(input logic par, rd, cd, ext, input lcd_port_pkg::width_t w,
		input lcd_port_pkg::pix_fmt_t p, input logic [31:0] d);
		i_req = '{to_parallel:par, is_read:rd, cd_sel:cd, from_ext:ext, width:w, pix:p};
		i_int_sram_data = ext ? ~d : d;
		i_ext_mem_data = ext ? d : ~d;
		i_req_valid = 1'b1;
		wait_ready();
		i_req_valid = 1'b0;
		wait_ready();
	endtask
	task automatic t_serial4();
		int          nb[6] = '{8, 9, 16, 18, 24, 32};
		logic [32:0] m;
		i_three_wire = 1'b0;
		for (int k = 0; k < 6; k++) begin
			m = (33'h1 << nb[k]) - 33'h1;
			send(0, 0, k[0], k[1], lcd_port_pkg::width_t'(k), lcd_port_pkg::PIX_RAW, 32'hc3a5_96e1);
			chk(33'(nb[k]), 33'(pm.cnt));
			chk(33'h0_c3a5_96e1 & m, pm.sr[32:0] & m);
			chk(33'(k[0]), 33'(pm.a0_s));
		end
		$display("serial four-wire done");
	endtask
	task automatic t_serial3();
		i_three_wire = 1'b1;
		send(0, 0, 1, 0, lcd_port_pkg::WID_9, lcd_port_pkg::PIX_RAW, 32'h0000_0155);
		chk(33'd10, 33'(pm.cnt));
		chk(33'h0_0000_0355, pm.sr[32:0] & 33'h0_0000_03ff);
		chk(33'd0, 33'(pm.a0_s));
		send(0, 0, 1, 1, lcd_port_pkg::WID_32, lcd_port_pkg::PIX_RAW, 32'h7000_000e);
		chk(33'd33, 33'(pm.cnt));
		chk(33'h1_7000_000e, pm.sr[32:0]);
		i_three_wire = 1'b0;
		$display("serial three-wire done");
	endtask
	task automatic t_par_write();
		logic [8:0] e[6] = '{9'h12c, 9'h0ac, 9'h162, 9'h165, 9'h0cb, 9'h12c};
		for (int k = 0; k < 6; k++) begin
			send(1, 0, k[0], k[1], lcd_port_pkg::WID_8, lcd_port_pkg::pix_fmt_t'(k), 32'h00b4_6d2c);
			chk(33'(e[k]), 33'(pm.wr_word));
			chk(33'(k[0]), 33'(pm.wr_a0));
		end
		$display("parallel write done");
	endtask
	task automatic t_par_read();
		send(1, 1, 1, 0, lcd_port_pkg::WID_8, lcd_port_pkg::PIX_RAW, 32'h0000_0000);
		chk(33'h0_01a5, 33'(o_rd_data));
		chk(33'd1, 33'(rdv_cnt));
		$display("parallel read done");
	endtask
	task automatic t_idle();
		i_enable = 1'b0;
		i_req_valid = 1'b1;
		repeat (4) @(posedge i_clk_sys);
		#1;
		chk(33'd0, 33'(o_req_ready));
		chk(33'd1, 33'(cs_n));
		chk(33'd0, 33'(sck));
		i_req_valid = 1'b0;
		i_enable = 1'b1;
		chk(33'd0, 33'(pm.viol));
		$display("idle and refusal done");
	endtask
	initial begin
		repeat (5) @(posedge i_clk_sys);
		#1;
		chk(33'd0, 33'(prst_n));
		i_rstn = 1'b1;
		i_enable = 1'b1;
		repeat (12) @(posedge i_clk_sys);
		#1;
		chk(33'd1, 33'(prst_n));
		t_serial4();
		t_serial3();
		t_par_write();
		t_par_read();
		t_idle();
		report_and_stop();
	end
endmodule
